// ---- hdl/sapr_pkg.sv ----
// constants and types shared by the converter power and readout logic
package sapr_pkg;

   // ******************************************************************
   // timing
   // ******************************************************************
   localparam int CLK_NS   = 20;
   localparam int WAKE_NS  = 350;
   // longest time: round down, never below one cycle
   localparam int WAKE_CYC = (WAKE_NS / CLK_NS) < 1 ? 1 : (WAKE_NS / CLK_NS);
   localparam int CNT_W    = 8;

   // ******************************************************************
   // power-down request counts
   // ******************************************************************
   localparam logic [2:0] LIGHT_PULSES = 3'h2;
   localparam logic [2:0] DEEP_PULSES  = 3'h4;

   // ******************************************************************
   // serial word layout
   // ******************************************************************
   localparam int WORD_W  = 16;
   localparam int RES_W   = 12;
   localparam int PAD_W   = 3;
   localparam int IDX_W   = 4;
   localparam logic [PAD_W-1:0] PAD_BITS = 3'h0;
   localparam logic [IDX_W-1:0] LAST_IDX = 4'hf;

   // ******************************************************************
   // power states, gray coded along active-light-deep
   // ******************************************************************
   typedef enum logic [1:0]
   {
      PWR_ACTIVE = 2'h0,
      PWR_LIGHT  = 2'h1,
      PWR_DEEP   = 2'h3,
      PWR_WAKE   = 2'h2
   } sapr_pwr_t;

endpackage

// ---- hdl/sapr_sync.sv ----
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module sapr_sync
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             clk_sys,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   typedef struct packed
   {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sapr_sync_st_t;

   sapr_sync_st_t q;
   sapr_sync_st_t d;

   // first stage feeds only the second stage
   always_comb
   begin
      d        = q;
      d.meta   = async_in;
      d.stable = q.meta;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign sync_out = q.stable;

endmodule // sapr_sync

// ---- hdl/sapr_core.sv ----
// power mode control and serial readout of the 12-bit sampling converter
//
// Notes on behaviour
// - after power-up the part is active and can convert at once
// - start pulsed twice with serial clock low enters light power-down
// - start pulsed four times with serial clock low enters deep power-down
// - light power-down turns off everything except the reference
// - deep power-down turns off everything, the reference too
// - a serial clock rising edge wakes either power-down state
// - after light power-down the part is ready within 350 ns
// - reference ready asserts only once reference settled and part can convert
// - reference ready bit goes out before the result bits
// - a start input rising edge begins a conversion
// - start requests are ignored until the running conversion completes
// - clock edge too soon after start delays output by one cycle
// - serial output changes only on serial clock rising edges and when a power-down forces it low
// - result straight binary unipolar, two's complement bipolar
// - ready bit is low whenever reference is below its nominal value
// - bipolar mode when negative supply is below ground
`timescale 1ns/1ps
module sapr_core
   import sapr_pkg::*;
#(
   parameter int T2_NS = 40
)
(
   input  wire logic             clk_sys,
   input  wire logic             nrst,
   input  wire logic             conv_pin,
   input  wire logic             sclk_pin,
   input  wire logic             ref_at_nominal,
   input  wire logic             vss_below_gnd,
   input  wire logic             conv_done,
   input  wire logic [RES_W-1:0] conv_data,
   output logic                  dout,
   output logic                  sample_start,
   output logic                  core_power_on,
   output logic                  ref_power_on,
   output logic                  reference_ready,
   output logic                  bipolar_mode
);

   // ******************************************************************
   // derived timing
   // ******************************************************************
   // least time: round up
   localparam int T2_RAW = (T2_NS + CLK_NS - 1) / CLK_NS;
   localparam int T2_CYC = T2_RAW < 1 ? 1 : T2_RAW;
   localparam logic [CNT_W-1:0] T2_LIM   = CNT_W'(T2_CYC);
   localparam logic [CNT_W-1:0] WAKE_LIM = CNT_W'(WAKE_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_MAX  = '1;

   // ******************************************************************
   // state
   // ******************************************************************
   typedef struct packed
   {
      sapr_pwr_t         pwr;
      logic              conv_prev;
      logic              sclk_prev;
      logic [2:0]        pulses;
      logic [CNT_W-1:0]  wake_cnt;
      logic              busy;
      logic              first_edge;
      logic [CNT_W-1:0]  since;
      logic [IDX_W-1:0]  bit_idx;
      logic [WORD_W-1:0] word;
      logic              dout;
      logic              sample_start;
      logic              core_on;
      logic              ref_on;
      logic              ref_rdy;
      logic              bipolar;
   } sapr_core_st_t;

   sapr_core_st_t q;
   sapr_core_st_t d;

   // ******************************************************************
   // pin synchronisers
   // ******************************************************************
   logic [3:0] pins_s;
   logic       conv_s;
   logic       sclk_s;
   logic       ref_ok_s;
   logic       vss_neg_s;

   // both pin clocks pass the same delay, so the start-to-clock gap holds
   sapr_sync #(.WIDTH(4)) u_sync
   (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .async_in ({vss_below_gnd, ref_at_nominal, sclk_pin, conv_pin}),
      .sync_out (pins_s)
   );

   assign conv_s    = pins_s[0];
   assign sclk_s    = pins_s[1];
   assign ref_ok_s  = pins_s[2];
   assign vss_neg_s = pins_s[3];

   // ******************************************************************
   // next state
   // ******************************************************************
   logic             conv_rise;
   logic             sclk_rise;
   logic [2:0]       pulses_nx;
   logic [RES_W-1:0] code;

   always_comb
   begin
      d              = q;
      d.sample_start = 1'b0;
      d.conv_prev    = conv_s;
      d.sclk_prev    = sclk_s;
      conv_rise      = conv_s & ~q.conv_prev;
      sclk_rise      = sclk_s & ~q.sclk_prev;
      pulses_nx      = q.pulses;

      // power-down request counting
      if (sclk_rise)
      begin
         pulses_nx = 3'h0;
      end
      else if (conv_rise && !sclk_s && q.pulses != DEEP_PULSES)
      begin
         pulses_nx = q.pulses + 3'h1;
      end
      d.pulses = pulses_nx;

      // power state
      unique case (q.pwr)
         PWR_ACTIVE:
         begin
            if (pulses_nx == LIGHT_PULSES && conv_rise)
            begin
               d.pwr = PWR_LIGHT;
            end
         end
         PWR_LIGHT:
         begin
            if (sclk_rise)
            begin
               d.pwr      = PWR_WAKE;
               d.wake_cnt = '0;
            end
            else if (pulses_nx == DEEP_PULSES && conv_rise)
            begin
               d.pwr = PWR_DEEP;
            end
         end
         PWR_DEEP:
         begin
            if (sclk_rise)
            begin
               d.pwr = PWR_ACTIVE;
            end
         end
         PWR_WAKE:
         begin
            // stays out of conversion until the wake delay is spent
            if (q.wake_cnt == WAKE_LIM)
            begin
               d.pwr = PWR_ACTIVE;
            end
            else
            begin
               d.wake_cnt = q.wake_cnt + CNT_W'(1);
            end
         end
      endcase

      d.core_on = (d.pwr == PWR_ACTIVE) || (d.pwr == PWR_WAKE);
      d.ref_on  = (d.pwr != PWR_DEEP);
      // ready needs a settled reference and a part able to convert
      d.ref_rdy = ref_ok_s && d.ref_on && (d.pwr == PWR_ACTIVE);
      d.bipolar = vss_neg_s;

      // result coding
      if (q.bipolar)
      begin
         code = {~conv_data[RES_W-1], conv_data[RES_W-2:0]};
      end
      else
      begin
         code = conv_data;
      end

      // conversion and readout
      if (q.busy)
      begin
         if (q.since != CNT_MAX)
         begin
            d.since = q.since + CNT_W'(1);
         end
         if (conv_done)
         begin
            d.word = {PAD_BITS, q.ref_rdy, code};
         end
         if (sclk_rise)
         begin
            d.first_edge = 1'b0;
            if (q.first_edge && q.since < T2_LIM)
            begin
               // edge too close to start: output slips one clock
               d.dout = 1'b0;
            end
            else
            begin
               d.dout    = q.word[LAST_IDX - q.bit_idx];
               d.bit_idx = q.bit_idx + IDX_W'(1);
               if (q.bit_idx == LAST_IDX)
               begin
                  d.busy = 1'b0;
               end
            end
         end
      end
      else if (conv_rise && q.pwr == PWR_ACTIVE)
      begin
         d.busy         = 1'b1;
         d.sample_start = 1'b1;
         d.first_edge   = 1'b1;
         d.since        = '0;
         d.bit_idx      = '0;
         d.word         = '0;
      end

      // a power-down abandons any conversion in flight
      // and never hands a start to a core that is switching off
      if (d.pwr == PWR_LIGHT || d.pwr == PWR_DEEP)
      begin
         d.busy         = 1'b0;
         d.dout         = 1'b0;
         d.sample_start = 1'b0;
      end
   end

   // ******************************************************************
   // registers
   // ******************************************************************
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         q         <= '0;
         q.pwr     <= PWR_ACTIVE;
         q.core_on <= 1'b1;
         q.ref_on  <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   // ******************************************************************
   // outputs
   // ******************************************************************
   assign dout            = q.dout;
   assign sample_start    = q.sample_start;
   assign core_power_on   = q.core_on;
   assign ref_power_on    = q.ref_on;
   assign reference_ready = q.ref_rdy;
   assign bipolar_mode    = q.bipolar;

endmodule // sapr_core

// ---- testbench/sapr_core_monitor.sv ----
// assertion checker bound to the converter power and readout block
`timescale 1ns/1ps
module sapr_core_monitor
   import sapr_pkg::*;
#(
   parameter int T2_NS = 40
)
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic conv_pin,
   input wire logic sclk_pin,
   input wire logic ref_at_nominal,
   input wire logic vss_below_gnd,
   input wire logic dout,
   input wire logic sample_start,
   input wire logic core_power_on,
   input wire logic ref_power_on,
   input wire logic reference_ready,
   input wire logic bipolar_mode
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   start_pulse_a: assert property (sample_start |=> !sample_start)
      else $error("start pulse too long");
   start_delay_a: assert property (sample_start |->
      $past(conv_pin, 3) && !$past(conv_pin, 4)) else $error("start late");
   start_power_a: assert property (sample_start |-> core_power_on)
      else $error("start while powered down");
   deep_ready_a: assert property (!ref_power_on |-> !reference_ready)
      else $error("ready while reference off");
   ready_nom_a: assert property (reference_ready |->
      $past(ref_at_nominal, 3)) else $error("ready with low reference");
   wake_edge_a: assert property ($rose(sclk_pin) |-> ##3
      (core_power_on && ref_power_on)) else $error("no wake on clock");
   dout_edge_a: assert property ($changed(dout) |-> !core_power_on ||
      ($past(sclk_pin, 3) && !$past(sclk_pin, 4))) else $error("dout moved");
   mode_follow_a: assert property ($past(nrst, 3) |->
      bipolar_mode == $past(vss_below_gnd, 3)) else $error("mode wrong");
endmodule // sapr_core_monitor

bind sapr_core sapr_core_monitor #(.T2_NS(T2_NS)) sapr_core_monitor_inst
(
   .clk_sys(clk_sys), .nrst(nrst), .conv_pin(conv_pin),
   .sclk_pin(sclk_pin), .ref_at_nominal(ref_at_nominal),
   .vss_below_gnd(vss_below_gnd), .dout(dout), .sample_start(sample_start),
   .core_power_on(core_power_on), .ref_power_on(ref_power_on),
   .reference_ready(reference_ready), .bipolar_mode(bipolar_mode)
);

// ---- testbench/sapr_conv_model.sv ----
// converter core stand-in: answers each start with one result
`timescale 1ns/1ps
module sapr_conv_model
   import sapr_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             sample_start,
   input  wire logic [RES_W-1:0] level,
   output logic                  conv_done = 1'b0,
   output logic      [RES_W-1:0] conv_data
);
   logic [1:0] dly_q = 2'h0;
   always_ff @(posedge clk_sys)
   begin
      dly_q     <= {dly_q[0], sample_start};
      conv_done <= dly_q[1];
      // inverse level outside done, so a stale capture shows up
      conv_data <= dly_q[1] ? level : ~level;
   end
endmodule // sapr_conv_model

// ---- testbench/tb_sapr_core.sv ----
// self-checking bench for the converter power and readout block
`timescale 1ns/1ps
module tb_sapr_core;
   import sapr_pkg::*;
   logic        clk_sys, nrst, conv_pin, sclk_pin, ref_at_nominal;
   logic        vss_below_gnd, conv_done, dout, sample_start;
   logic        core_power_on, ref_power_on, reference_ready, bipolar_mode;
   logic [11:0] level, conv_data;
   int          n_mismatch = 0, tests_run = 0, n_start = 0;

   sapr_core #(.T2_NS(40)) sapr_core_inst
   (
      .clk_sys(clk_sys), .nrst(nrst), .conv_pin(conv_pin),
      .sclk_pin(sclk_pin), .ref_at_nominal(ref_at_nominal),
      .vss_below_gnd(vss_below_gnd), .conv_done(conv_done),
      .conv_data(conv_data), .dout(dout), .sample_start(sample_start),
      .core_power_on(core_power_on), .ref_power_on(ref_power_on),
      .reference_ready(reference_ready), .bipolar_mode(bipolar_mode)
   );
   sapr_conv_model sapr_conv_model_inst
   (
      .clk_sys(clk_sys), .sample_start(sample_start), .level(level),
      .conv_done(conv_done), .conv_data(conv_data)
   );

   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
      if (sample_start === 1'b1) n_start++;

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic chk(input string name, input logic [15:0] exp, got);
      tests_run++;
      if (exp !== got)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   // one word; a second start mid word must be ignored
   task automatic read_word(input logic [15:0] exp, input string name);
      logic [15:0] w;
      int          i, s0;
      s0 = n_start;
      @(posedge clk_sys);
      conv_pin <= 1'b1;
      cyc(8);
      conv_pin <= 1'b0;
      for (i = 0; i < 16; i++)
      begin
         sclk_pin <= 1'b1;
         if (i == 3) conv_pin <= 1'b1;
         cyc(4);
         w = {w[14:0], dout};
         sclk_pin <= 1'b0;
         cyc(4);
      end
      conv_pin <= 1'b0;
      chk(name, exp, w);
      chk("starts", 16'h1, 16'(n_start - s0));
   endtask
   // start with the clock close behind: one slipped bit comes first
   task automatic read_slip(input logic [15:0] exp, input string name);
      logic [15:0] w;
      int          i;
      @(posedge clk_sys);
      conv_pin <= 1'b1;
      cyc(1);
      for (i = 0; i < 17; i++)
      begin
         sclk_pin <= 1'b1;
         cyc(4);
         if (i > 0) w = {w[14:0], dout};
         sclk_pin <= 1'b0;
         cyc(4);
      end
      conv_pin <= 1'b0;
      chk(name, exp, w);
   endtask
   // pulse start n times with clock low, then wake on a clock rise
   task automatic power(input int n, input logic [2:0] exp, input string nm);
      int i, s0;
      for (i = 0; i < n; i++)
      begin
         conv_pin <= 1'b1;
         cyc(4);
         conv_pin <= 1'b0;
         cyc(4);
      end
      // reference switched off: its level sinks below nominal
      if (!exp[1]) ref_at_nominal <= 1'b0;
      chk(nm, 16'(exp), {13'h0, core_power_on, ref_power_on,
         reference_ready});
      sclk_pin <= 1'b1;
      cyc(6);
      chk("wake", 16'h6, {13'h0, core_power_on, ref_power_on,
         reference_ready});
      if (exp[1])
      begin
         // clock held high so the refused start is not counted as a pulse
         s0 = n_start;
         conv_pin <= 1'b1;
         cyc(8);
         chk("wake start", 16'h0, 16'(n_start - s0));
         conv_pin <= 1'b0;
      end
      sclk_pin <= 1'b0;
      cyc(20);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      #400us;
      n_mismatch++;
      report_and_stop;
   end
   initial
   begin
      nrst = 1'b0;
      conv_pin = 1'b0;
      sclk_pin = 1'b0;
      ref_at_nominal = 1'b1;
      vss_below_gnd = 1'b0;
      level = 12'hfff;
      cyc(2);
      nrst <= 1'b1;
      cyc(1);
      chk("power up", 16'h3, {14'h0, core_power_on, ref_power_on});
      cyc(4);
      read_word(16'h1fff, "unipolar");
      vss_below_gnd <= 1'b1;
      level <= 12'h001;
      read_word(16'h1801, "bipolar");
      vss_below_gnd <= 1'b0;
      level <= 12'hbe6;
      cyc(4);
      power(2, 3'b010, "light");
      read_word(16'h1be6, "after light");
      cyc(4);
      power(4, 3'b000, "deep");
      ref_at_nominal <= 1'b0;
      read_word(16'h0be6, "low reference");
      ref_at_nominal <= 1'b1;
      cyc(8);
      read_word(16'h1be6, "settled");
      read_slip(16'h1be6, "slipped");
      report_and_stop;
   end
endmodule // tb_sapr_core
